/* slp_pkg.sv */
// Purpose: shared constants for the slot level, pitch and slow oscillator block
// Assumes: 10 MHz clock, 32-bit APB register bus
// Notes: attenuation is kept in steps of one sixteenth octave (about 0.375 dB)
package slp_pkg;

    // ************************************************
    // clock and widths
    // ************************************************
    localparam int unsigned CLOCK_HZ = 10_000_000;
    localparam int SAMPLE_W = 16;
    localparam int STEP_W = 25;
    localparam int PHASE_W = 32;

    // ************************************************
    // register map (byte addresses)
    // ************************************************
    localparam logic [7:0] OFS_LEVEL = 8'h00;
    localparam logic [7:0] OFS_PITCH = 8'h04;
    localparam logic [7:0] OFS_OSC = 8'h08;
    localparam logic [7:0] OFS_MOD_STATUS = 8'h0C;
    localparam logic [7:0] OFS_STEP_STATUS = 8'h10;

    // level register fields
    localparam int TL_LSB = 0;
    localparam int BYPASS_BIT = 8;
    // pitch register fields
    localparam int FINE_LSB = 0;
    localparam int OCT_LSB = 12;
    // oscillator register fields
    localparam int HOLD_BIT = 0;
    localparam int RATE_LSB = 1;
    localparam int AM_WAVE_LSB = 8;
    localparam int AM_DEPTH_LSB = 10;
    localparam int PM_WAVE_LSB = 16;
    localparam int PM_DEPTH_LSB = 18;

    // reset values
    localparam logic [7:0] RST_TL = 8'h00;
    localparam logic RST_BYPASS = 1'b0;
    localparam logic [9:0] RST_FINE = 10'h000;
    localparam logic [3:0] RST_OCT = 4'h0;
    localparam logic RST_HOLD = 1'b0;
    localparam logic [4:0] RST_RATE = 5'h00;
    localparam logic [1:0] RST_WAVE = 2'h0;
    localparam logic [2:0] RST_DEPTH = 3'h0;
    localparam logic [15:0] RST_NOISE_SEED = 16'hACE1;

    // ************************************************
    // datapath constants
    // ************************************************
    localparam logic [10:0] UNITY_FINE = 11'h400;
    localparam logic [8:0] ROUND_HALF = 9'h080;
    localparam logic [10:0] ATT_MUTE = 11'h100;
    localparam int MANT_FRAC = 15;
    localparam int PM_DEPTH_SHIFT = 7;
    localparam int PROD_TO_STEP = 4;

    typedef enum logic [3:0] {
        SLP_SAW = 4'b0001,
        SLP_RECT = 4'b0010,
        SLP_TRI = 4'b0100,
        SLP_NOISE = 4'b1000
    } slp_wave_t;

    // 2^(-k/16) in Q15
    function automatic logic [15:0] slp_mant(input logic [3:0] k);
        case (k)
            4'h0: slp_mant = 16'h8000;
            4'h1: slp_mant = 16'h7A93;
            4'h2: slp_mant = 16'h7560;
            4'h3: slp_mant = 16'h7066;
            4'h4: slp_mant = 16'h6BA2;
            4'h5: slp_mant = 16'h6712;
            4'h6: slp_mant = 16'h62B4;
            4'h7: slp_mant = 16'h5E84;
            4'h8: slp_mant = 16'h5A82;
            4'h9: slp_mant = 16'h56AC;
            4'hA: slp_mant = 16'h52FF;
            4'hB: slp_mant = 16'h4F7B;
            4'hC: slp_mant = 16'h4C1C;
            4'hD: slp_mant = 16'h48E2;
            4'hE: slp_mant = 16'h45CB;
            default: slp_mant = 16'h42D5;
        endcase
    endfunction

    // peak level swing in attenuation steps: 0, .4, .8, 1.5, 3, 6, 12, 24 dB
    function automatic logic [7:0] slp_am_peak(input logic [2:0] d);
        case (d)
            3'h0: slp_am_peak = 8'h00;
            3'h1: slp_am_peak = 8'h01;
            3'h2: slp_am_peak = 8'h02;
            3'h3: slp_am_peak = 8'h04;
            3'h4: slp_am_peak = 8'h08;
            3'h5: slp_am_peak = 8'h10;
            3'h6: slp_am_peak = 8'h20;
            default: slp_am_peak = 8'h40;
        endcase
    endfunction

    // peak pitch swing in fine-number units: 0, 7, 13.5, 27, 55, 112, 230, 494 cent
    function automatic logic [9:0] slp_pm_peak(input logic [2:0] d);
        case (d)
            3'h0: slp_pm_peak = 10'h000;
            3'h1: slp_pm_peak = 10'h004;
            3'h2: slp_pm_peak = 10'h008;
            3'h3: slp_pm_peak = 10'h010;
            3'h4: slp_pm_peak = 10'h021;
            3'h5: slp_pm_peak = 10'h044;
            3'h6: slp_pm_peak = 10'h090;
            default: slp_pm_peak = 10'h155;
        endcase
    endfunction

    // oscillator rate in hundredths of a hertz
    function automatic int unsigned slp_rate_chz(input logic [4:0] r);
        case (r)
            5'h00: slp_rate_chz = 17;
            5'h01: slp_rate_chz = 19;
            5'h02: slp_rate_chz = 23;
            5'h03: slp_rate_chz = 27;
            5'h04: slp_rate_chz = 34;
            5'h05: slp_rate_chz = 39;
            5'h06: slp_rate_chz = 45;
            5'h07: slp_rate_chz = 55;
            5'h08: slp_rate_chz = 68;
            5'h09: slp_rate_chz = 78;
            5'h0A: slp_rate_chz = 92;
            5'h0B: slp_rate_chz = 110;
            5'h0C: slp_rate_chz = 139;
            5'h0D: slp_rate_chz = 160;
            5'h0E: slp_rate_chz = 187;
            5'h0F: slp_rate_chz = 227;
            5'h10: slp_rate_chz = 287;
            5'h11: slp_rate_chz = 331;
            5'h12: slp_rate_chz = 392;
            5'h13: slp_rate_chz = 479;
            5'h14: slp_rate_chz = 615;
            5'h15: slp_rate_chz = 718;
            5'h16: slp_rate_chz = 860;
            5'h17: slp_rate_chz = 1080;
            5'h18: slp_rate_chz = 1440;
            5'h19: slp_rate_chz = 1720;
            5'h1A: slp_rate_chz = 2150;
            5'h1B: slp_rate_chz = 2870;
            5'h1C: slp_rate_chz = 4310;
            5'h1D: slp_rate_chz = 5740;
            5'h1E: slp_rate_chz = 8610;
            default: slp_rate_chz = 17230;
        endcase
    endfunction

    // phase increment per clock for a full 2^32 cycle
    function automatic logic [31:0] slp_rate_inc(input logic [4:0] r);
        longint unsigned num;
        num = longint'(slp_rate_chz(r)) << PHASE_W;
        slp_rate_inc = 32'(num / (longint'(100) * longint'(CLOCK_HZ)));
    endfunction

endpackage

/* slp_slot.sv */
// Purpose: one sound slot's level, pitch step and slow modulation oscillator
// Assumes: sound data and envelope gain come from logic on the same clock
// Notes: registers reached over APB; answer is given with zero wait states
//
// Summary of operation
// - attenuation is sum of weighted level bits
// - amplitude scaled by product of bit ratios
// - bypass flag skips envelope, level and amplitude modulation
// - octave field shifts pitch by whole octaves
// - zero fine and octave give source rate
// - rate scaled by (1024 + fine) / 1024
// - each slot has its own oscillator
// - four waves, code 3 is noise
// - noise ignores hold and rate
// - separate wave and depth per side
// - hold bit 1 resets, 0 runs oscillator
// - five-bit rate code picks table frequency
// - amplitude depth codes 1..6 give 0.4..12 dB
// - pitch depth codes 1..6 give 7..230 cent
// - both outputs 8 bits, pitch signed
// - amplitude depth 7 gives 24 dB
// - pitch depth 7 gives 494 cent
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
module slp_slot (
    input wire logic i_clock,                                     // 10 MHz clock
    input wire logic i_resetn,                                    // async reset, active low
    input wire logic i_psel,                                      // apb select
    input wire logic i_penable,                                   // apb access phase
    input wire logic i_pwrite,                                    // apb write
    input wire logic [7:0] i_paddr,                               // apb byte address
    input wire logic [31:0] i_pwdata,                             // apb write data
    output logic [31:0] o_prdata,                                 // apb read data
    output logic o_pready,                                        // apb ready
    output logic o_pslverr,                                       // apb error, unmapped address
    input wire logic signed [slp_pkg::SAMPLE_W-1:0] i_sample,     // slot sound data
    input wire logic [9:0] i_envelope_gain,                       // envelope attenuation steps
    output logic signed [slp_pkg::SAMPLE_W-1:0] o_sample,         // scaled slot output
    output logic [slp_pkg::STEP_W-1:0] o_phase_step,              // waveform step, 16 fraction bits
    output logic [7:0] o_amp_mod_value,                           // amplitude modulation value
    output logic signed [7:0] o_pitch_mod_value                   // pitch modulation value
);
    import slp_pkg::*;

    // ************************************************
    // registers
    // ************************************************
    logic [7:0] total_level_attenuation;
    logic direct_bypass_flag;
    logic [9:0] fine_pitch_number;
    logic [3:0] octave_shift_field;
    logic slow_osc_hold;
    logic [4:0] slow_osc_rate;
    logic [1:0] amp_mod_wave_select;
    logic [2:0] amp_mod_depth;
    logic [1:0] pitch_mod_wave_select;
    logic [2:0] pitch_mod_depth;

    logic setup_phase;
    logic access_phase;
    logic addr_hit;
    logic [31:0] next_prdata;

    assign setup_phase = i_psel & ~i_penable;
    assign access_phase = i_psel & i_penable;
    assign o_pready = 1'b1;

    always_comb begin
        addr_hit = 1'b1;
        next_prdata = 32'h0000_0000;
        case (i_paddr)
            OFS_LEVEL: begin
                next_prdata[TL_LSB +: 8] = total_level_attenuation;
                next_prdata[BYPASS_BIT] = direct_bypass_flag;
            end
            OFS_PITCH: begin
                next_prdata[FINE_LSB +: 10] = fine_pitch_number;
                next_prdata[OCT_LSB +: 4] = octave_shift_field;
            end
            OFS_OSC: begin
                next_prdata[HOLD_BIT] = slow_osc_hold;
                next_prdata[RATE_LSB +: 5] = slow_osc_rate;
                next_prdata[AM_WAVE_LSB +: 2] = amp_mod_wave_select;
                next_prdata[AM_DEPTH_LSB +: 3] = amp_mod_depth;
                next_prdata[PM_WAVE_LSB +: 2] = pitch_mod_wave_select;
                next_prdata[PM_DEPTH_LSB +: 3] = pitch_mod_depth;
            end
            OFS_MOD_STATUS: begin
                next_prdata[15:0] = {o_pitch_mod_value, o_amp_mod_value};
            end
            OFS_STEP_STATUS: begin
                next_prdata[STEP_W-1:0] = o_phase_step;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // read data captured in the setup cycle so it leaves a flip-flop
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_prdata <= 32'h0000_0000;
        end else if (setup_phase) begin
            o_prdata <= next_prdata;
        end
    end

    assign o_pslverr = access_phase & ~addr_hit;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            total_level_attenuation <= RST_TL;
            direct_bypass_flag <= RST_BYPASS;
            fine_pitch_number <= RST_FINE;
            octave_shift_field <= RST_OCT;
            slow_osc_hold <= RST_HOLD;
            slow_osc_rate <= RST_RATE;
            amp_mod_wave_select <= RST_WAVE;
            amp_mod_depth <= RST_DEPTH;
            pitch_mod_wave_select <= RST_WAVE;
            pitch_mod_depth <= RST_DEPTH;
        end else if (access_phase && i_pwrite) begin
            case (i_paddr)
                OFS_LEVEL: begin
                    total_level_attenuation <= i_pwdata[TL_LSB +: 8];
                    direct_bypass_flag <= i_pwdata[BYPASS_BIT];
                end
                OFS_PITCH: begin
                    fine_pitch_number <= i_pwdata[FINE_LSB +: 10];
                    octave_shift_field <= i_pwdata[OCT_LSB +: 4];
                end
                OFS_OSC: begin
                    slow_osc_hold <= i_pwdata[HOLD_BIT];
                    slow_osc_rate <= i_pwdata[RATE_LSB +: 5];
                    amp_mod_wave_select <= i_pwdata[AM_WAVE_LSB +: 2];
                    amp_mod_depth <= i_pwdata[AM_DEPTH_LSB +: 3];
                    pitch_mod_wave_select <= i_pwdata[PM_WAVE_LSB +: 2];
                    pitch_mod_depth <= i_pwdata[PM_DEPTH_LSB +: 3];
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************
    // slow oscillator, private to this slot
    // ************************************************
    logic [PHASE_W-1:0] osc_phase;
    logic [15:0] noise_lfsr;
    logic [7:0] ph;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            osc_phase <= '0;
        end else if (slow_osc_hold) begin
            osc_phase <= '0;
        end else begin
            osc_phase <= osc_phase + slp_rate_inc(slow_osc_rate);
        end
    end

    // noise free-runs: neither hold nor rate touch it
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            noise_lfsr <= RST_NOISE_SEED;
        end else begin
            noise_lfsr <= {noise_lfsr[14:0], noise_lfsr[15] ^ noise_lfsr[13] ^ noise_lfsr[12] ^ noise_lfsr[10]};
        end
    end

    assign ph = osc_phase[PHASE_W-1 -: 8];

    function automatic slp_wave_t decode_wave(input logic [1:0] sel);
        case (sel)
            2'h0: decode_wave = SLP_SAW;
            2'h1: decode_wave = SLP_RECT;
            2'h2: decode_wave = SLP_TRI;
            default: decode_wave = SLP_NOISE;
        endcase
    endfunction

    slp_wave_t amp_wave;
    slp_wave_t pitch_wave;
    logic [7:0] tri_up;
    logic [7:0] next_amp;
    logic [7:0] next_pitch;

    assign amp_wave = decode_wave(amp_mod_wave_select);
    assign pitch_wave = decode_wave(pitch_mod_wave_select);
    assign tri_up = ph[7] ? ~{ph[6:0], 1'b0} : {ph[6:0], 1'b0};

    // amplitude side: 00 no attenuation, FF deepest
    always_comb begin
        case (amp_wave)
            SLP_SAW: next_amp = ph;
            SLP_RECT: next_amp = ph[7] ? 8'hFF : 8'h00;
            SLP_TRI: next_amp = tri_up;
            SLP_NOISE: next_amp = noise_lfsr[7:0];
            default: next_amp = 8'h00;
        endcase
    end

    // pitch side: signed, 7F top, 80 bottom
    always_comb begin
        case (pitch_wave)
            SLP_SAW: next_pitch = ph ^ 8'h80;
            SLP_RECT: next_pitch = ph[7] ? 8'h80 : 8'h7F;
            SLP_TRI: next_pitch = tri_up ^ 8'h80;
            SLP_NOISE: next_pitch = noise_lfsr[15:8];
            default: next_pitch = 8'h00;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_amp_mod_value <= 8'h00;
            o_pitch_mod_value <= 8'sh00;
        end else begin
            o_amp_mod_value <= next_amp;
            o_pitch_mod_value <= next_pitch;
        end
    end

    // ************************************************
    // level path
    // ************************************************
    // level code is linear in log steps, so bit weights add (48 dB .. 0.4 dB)
    logic [16:0] am_prod;
    logic [8:0] am_att;
    logic [10:0] total_att;
    logic signed [32:0] level_prod;
    logic signed [32:0] level_shifted;
    logic signed [SAMPLE_W-1:0] next_sample;

    assign am_prod = 17'(o_amp_mod_value * slp_am_peak(amp_mod_depth)) + 17'(ROUND_HALF);
    assign am_att = am_prod[16:8];
    assign total_att = 11'(total_level_attenuation) + 11'(i_envelope_gain) + 11'(am_att);

    // mantissa times whole-octave shift gives the per-bit ratio product
    assign level_prod = i_sample * $signed({1'b0, slp_mant(total_att[3:0])});
    assign level_shifted = (level_prod >>> MANT_FRAC) >>> total_att[7:4];

    always_comb begin
        if (direct_bypass_flag) begin
            next_sample = i_sample;
        end else if (total_att >= ATT_MUTE) begin
            // beyond 96 dB the result is below one step anyway
            next_sample = '0;
        end else begin
            next_sample = level_shifted[SAMPLE_W-1:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sample <= '0;
        end else begin
            o_sample <= next_sample;
        end
    end

    // ************************************************
    // pitch path
    // ************************************************
    // linear approximation of the cent swing; error grows toward depth 7
    logic signed [18:0] pm_prod;
    logic signed [18:0] pm_delta;
    logic [10:0] pm_factor;
    logic [21:0] rate_prod;
    logic [17:0] base_step;
    logic [STEP_W-1:0] next_step;
    logic [3:0] down_shift;

    assign pm_prod = o_pitch_mod_value * $signed({1'b0, slp_pm_peak(pitch_mod_depth)});
    assign pm_delta = pm_prod >>> PM_DEPTH_SHIFT;
    assign pm_factor = 11'($signed({8'h00, UNITY_FINE}) + pm_delta);
    assign rate_prod = (UNITY_FINE + 11'(fine_pitch_number)) * pm_factor;
    assign base_step = rate_prod[PROD_TO_STEP +: 18];
    assign down_shift = 4'h0 - octave_shift_field;

    always_comb begin
        if (!octave_shift_field[3]) begin
            next_step = STEP_W'(base_step) << octave_shift_field[2:0];
        end else begin
            next_step = STEP_W'(base_step) >> down_shift;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_phase_step <= '0;
        end else begin
            o_phase_step <= next_step;
        end
    end

endmodule

/* slp_slot_asserts.sv */
// Purpose: port checks for one slot's level, pitch and slow oscillator
// Assumes: register shadows follow apb writes seen at the ports
// Notes: checks wait three edges after any write
`timescale 1ns/10ps
module slp_slot_asserts
    import slp_pkg::*;
(
    input wire logic i_clock, // clock
    input wire logic i_resetn, // reset
    input wire logic i_psel, // select
    input wire logic i_penable, // access
    input wire logic i_pwrite, // write
    input wire logic [7:0] i_paddr, // address
    input wire logic [31:0] i_pwdata, // write data
    input wire logic signed [slp_pkg::SAMPLE_W-1:0] i_sample, // sound in
    input wire logic [9:0] i_envelope_gain, // envelope
    input wire logic signed [slp_pkg::SAMPLE_W-1:0] o_sample, // sound out
    input wire logic [slp_pkg::STEP_W-1:0] o_phase_step, // step
    input wire logic [7:0] o_amp_mod_value, // amp value
    input wire logic signed [7:0] o_pitch_mod_value // pitch value
);
    import slp_pkg::*;
    // ************************************************
    // register shadows
    // ************************************************
    logic [31:0] lv, pt, os;
    logic [1:0] qt;
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            lv <= 32'h0;
            pt <= 32'h0;
            os <= 32'h0;
        end else if (i_psel && i_penable && i_pwrite) begin
            if (i_paddr == OFS_LEVEL) lv <= i_pwdata;
            if (i_paddr == OFS_PITCH) pt <= i_pwdata;
            if (i_paddr == OFS_OSC) os <= i_pwdata;
        end
    end
    // outputs lag a write by up to three edges
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) qt <= 2'd0;
        else if (i_psel && i_penable && i_pwrite) qt <= 2'd0;
        else if (qt != 2'd3) qt <= qt + 2'd1;
    end
    function automatic logic [24:0] f_step(input logic [15:0] p);
        logic [24:0] b;
        b = 25'(11'h400 + 11'(p[9:0])) << 6;
        f_step = p[15] ? b >> (5'd16 - 5'(p[15:12])) : b << p[15:12];
    endfunction
    // ************************************************
    // properties
    // ************************************************
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);
    sequence s_quiet;
        qt == 2'd3;
    endsequence
    property p_bypass;
        s_quiet ##0 lv[8] |=> o_sample == $past(i_sample);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass output differs");
    property p_level;
        logic [3:0] sh;
        (s_quiet ##0 (!lv[8] && lv[3:0] == 4'h0 && os[12:10] == 3'h0 && i_envelope_gain == 10'h0), sh = lv[7:4])
            |=> o_sample == ($past(i_sample) >>> sh);
    endproperty
    a_level: assert property (p_level) else $error("level scaling wrong");
    property p_src;
        s_quiet ##0 (pt[15:0] == 16'h0 && os[20:18] == 3'h0) |-> o_phase_step == 25'h0010000;
    endproperty
    a_src: assert property (p_src) else $error("source rate step wrong");
    property p_oct;
        s_quiet ##0 os[20:18] == 3'h0 |-> o_phase_step == f_step(pt[15:0]);
    endproperty
    a_oct: assert property (p_oct) else $error("octave or fine step wrong");
    property p_hold;
        s_quiet ##0 (os[0] && os[9:8] != 2'd3 && os[17:16] != 2'd3) |->
            o_amp_mod_value == 8'h00 && $unsigned(o_pitch_mod_value) == (os[17:16] == 2'd1 ? 8'h7F : 8'h80);
    endproperty
    a_hold: assert property (p_hold) else $error("held oscillator not at phase zero");
    property p_saw;
        s_quiet ##0 (os[9:8] == os[17:16] && !os[8]) |-> $unsigned(o_pitch_mod_value) == (o_amp_mod_value ^ 8'h80);
    endproperty
    a_saw: assert property (p_saw) else $error("saw or triangle sides disagree");
    property p_rect;
        s_quiet ##0 (os[9:8] == 2'd1 && os[17:16] == 2'd1) |->
            (o_amp_mod_value == 8'hFF || o_amp_mod_value == 8'h00)
            && ((o_amp_mod_value == 8'hFF) == ($unsigned(o_pitch_mod_value) == 8'h80));
    endproperty
    a_rect: assert property (p_rect) else $error("rectangle levels wrong");
    property p_noise;
        s_quiet ##0 os[9:8] == 2'd3 |-> ##[1:20] ($changed(o_amp_mod_value) || qt != 2'd3);
    endproperty
    a_noise: assert property (p_noise) else $error("noise stuck");
endmodule
bind slp_slot slp_slot_asserts u_chk (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_sample(i_sample),
    .i_envelope_gain(i_envelope_gain), .o_sample(o_sample), .o_phase_step(o_phase_step),
    .o_amp_mod_value(o_amp_mod_value), .o_pitch_mod_value(o_pitch_mod_value)
);

/* test_slot_level_pitch_lfo.sv */
// Purpose: self-checking bench for one slot's level, pitch and slow oscillator
// Assumes: apb master waits for pready under a bound
// Notes: only the two fastest rates are timed
`timescale 1ns/10ps
module test_slot_level_pitch_lfo;
    import slp_pkg::*;
    localparam logic signed [15:0] SMP = 16'shC000;
    logic i_clock, i_resetn, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic [7:0] i_paddr, o_amp_mod_value;
    logic [31:0] i_pwdata, o_prdata;
    logic signed [SAMPLE_W-1:0] i_sample, o_sample;
    logic [9:0] i_envelope_gain;
    logic [STEP_W-1:0] o_phase_step;
    logic signed [7:0] o_pitch_mod_value;
    int n_errors = 0;
    int n_checks = 0;
    slp_slot DUT (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_sample(i_sample),
        .i_envelope_gain(i_envelope_gain), .o_sample(o_sample), .o_phase_step(o_phase_step),
        .o_amp_mod_value(o_amp_mod_value), .o_pitch_mod_value(o_pitch_mod_value)
    );
    // ************************************************
    // shared tasks
    // ************************************************
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        n_checks++;
        if (got !== want) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic wait_out;
        n_errors++;
        $display("BAD %0t wait ran out", $time);
        tally_and_finish();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_pready !== 1'b1 && n < 16);
        if (o_pready !== 1'b1) wait_out();
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] want, input logic ew);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, want);
        chk(32'(e), 32'(ew));
    endtask
    // counts edges until the amplitude value moves
    task automatic wait_change(output int n);
        logic [7:0] v;
        v = o_amp_mod_value;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_amp_mod_value === v && n < 4000);
        if (o_amp_mod_value === v) wait_out();
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_regs;
        rd(OFS_LEVEL, 32'h0, 1'b0);
        rd(OFS_OSC, 32'h0, 1'b0);
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14, 32'h0, 1'b1);
        wr(OFS_PITCH, 32'hFFFF_FFFF);
        wr(OFS_STEP_STATUS, 32'h0);
        rd(OFS_PITCH, 32'h0000_F3FF, 1'b0);
        rd(OFS_STEP_STATUS, 32'h0000_FFE0, 1'b0);
    endtask
    task automatic t_level;
        wr(OFS_PITCH, 32'h0);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_LEVEL, 32'h10 << k);
            repeat (4) @(posedge i_clock);
            chk(32'(o_sample), 32'(SMP >>> (1 << k)));
        end
        i_envelope_gain <= 10'h3FF;
        wr(OFS_LEVEL, 32'h1FF);
        repeat (4) @(posedge i_clock);
        chk(32'(o_sample), 32'(SMP));
        i_envelope_gain <= 10'h000;
        wr(OFS_LEVEL, 32'h0);
    endtask
    task automatic t_pitch;
        logic [3:0] oc [6] = '{4'h0, 4'h0, 4'h1, 4'hF, 4'h7, 4'h8};
        logic [9:0] fn [6] = '{10'h0, 10'h3FF, 10'h0, 10'h0, 10'h0, 10'h0};
        // 1024*(2^(c/1200)-1) per depth code
        int pk [8] = '{0, 4, 8, 16, 33, 68, 144, 341};
        logic [24:0] b;
        for (int k = 0; k < 6; k++) begin
            wr(OFS_PITCH, {16'h0, oc[k], 2'b00, fn[k]});
            repeat (4) @(posedge i_clock);
            b = 25'(11'h400 + 11'(fn[k])) << 6;
            b = oc[k][3] ? b >> (16 - oc[k]) : b << oc[k];
            chk(32'(o_phase_step), 32'(b));
        end
        wr(OFS_PITCH, 32'h0);
        for (int k = 1; k < 8; k++) begin
            wr(OFS_OSC, 32'(k) << PM_DEPTH_LSB | 32'h1);
            repeat (4) @(posedge i_clock);
            chk(32'(o_phase_step), 32'(1024 - pk[k]) << 6);
        end
        chk({24'h0, o_pitch_mod_value}, 32'h80);
    endtask
    task automatic t_osc;
        int n, t;
        real want;
        wr(OFS_OSC, 32'h3_0301);
        wait_change(n);
        chk(32'(n < 40), 32'h1);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_OSC, k == 0 ? 32'h3E : 32'h2_023C);
            repeat (2) wait_change(n);
            t = 0;
            repeat (4) begin
                wait_change(n);
                t += n;
            end
            want = 4.0e7 / ((k == 0 ? 172.3 : 86.1) * 256.0);
            chk(32'(t > want * 0.98 && t < want * 1.02), 32'h1);
            chk({24'h0, o_pitch_mod_value ^ 8'h80}, {24'h0, o_amp_mod_value});
        end
        wr(OFS_OSC, 32'h1_1D3E);
        t = 0;
        while (o_amp_mod_value !== 8'hFF && t < 70000) begin
            @(posedge i_clock);
            t++;
        end
        if (o_amp_mod_value !== 8'hFF) wait_out();
        repeat (3) @(posedge i_clock);
        chk(32'(o_sample), 32'(SMP >>> 4));
        wr(OFS_OSC, 32'h1_193E);
        repeat (4) @(posedge i_clock);
        chk(32'(o_sample), 32'(SMP >>> 2));
    endtask
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end
    initial begin
        i_resetn = 1'b0;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 8'h00;
        i_pwdata = 32'h0;
        i_sample = SMP;
        i_envelope_gain = 10'h000;
        repeat (4) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        t_regs();
        t_level();
        t_pitch();
        t_osc();
        tally_and_finish();
    end
endmodule
